// File: serdes_config_control.sv
`timescale 1ns/1ps
module serdes_config_control
   import serdes_cfg_pkg::*;
(
   // Clock and reset
   input wire logic CLK_IN,
   input wire logic RST_B_IN,
   // Register port
   input wire logic [2:0] ADDR_IN,
   input wire logic [7:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   output logic [7:0] RDATA_OUT,
   output logic IRQ_OUT,
   // Clock source ticks
   input wire logic OSC_TICK_IN,
   input wire logic PLL_TICK_IN,
   // Serial line
   input wire logic RX_DATA_IN,
   input wire logic CARRIER_IN,
   output logic SHIFT_CLK_OUT,
   output logic TX_DATA_OUT,
   output logic TX_ACTIVE_OUT,
   // Protocol mode
   output logic USB_LOW_OUT,
   output logic USB_HIGH_OUT,
   // Word streams
   output logic [31:0] RX_WORD_OUT,
   output logic RX_VALID_OUT,
   input wire logic [31:0] TX_WORD_IN,
   input wire logic TX_VALID_IN,
   output logic TX_READY_OUT
);
   logic [7:0] mode_r;
   logic [6:0] rxcfg_r;
   logic [1:0] crs_ctrl_r;
   logic [7:0] txcfg_r;
   logic [2:0] mask_r;
   logic [3:0] proto;
   logic [1:0] sub;
   logic [1:0] clk_src;
   logic proto_ok;
   logic tick;
   logic sclk_r;
   logic rise_ev;
   logic fall_ev;
   logic samp_rise;
   logic drive_rise;
   logic sample_ev;
   logic drive_ev;
   logic rx_bit;
   logic [31:0] rx_shift_r;
   logic [4:0] rx_cnt_r;
   logic [5:0] rx_tgt;
   logic rx_done;
   logic sync_hit;
   logic carrier_r;
   logic crs_ev;
   logic [5:0] tx_tgt;
   logic [5:0] tx_left_r;
   logic [31:0] tx_shift_r;
   logic [31:0] tx_hold_r;
   logic tx_hold_v_r;
   logic tx_load;
   logic ser_en;
   tx_state_type tx_state_r;
   logic stat_rd;
   logic [2:0] stat;
   logic [7:0] rdata_nxt;

   // Configuration registers
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         mode_r <= RST_MODE;
         rxcfg_r <= RST_RXCFG;
         crs_ctrl_r <= RST_CRS;
         txcfg_r <= RST_TXCFG;
         mask_r <= RST_MASK;
      end else if (WR_IN) begin
         case (ADDR_IN)
            OFS_MODE: mode_r <= WDATA_IN;
            OFS_RXCFG: rxcfg_r <= WDATA_IN[6:0];
            OFS_RXCNT: crs_ctrl_r <= WDATA_IN[RXCNT_CRS_LSB +: 2];
            OFS_TXCFG: txcfg_r <= {WDATA_IN[7], 1'b0, WDATA_IN[5:0]};
            OFS_MASK: mask_r <= WDATA_IN[2:0];
            default: ;
         endcase
      end
   end

   assign proto = mode_r[MODE_PROTO_LSB +: 4];
   assign sub = mode_r[MODE_SUB_LSB +: 2];
   assign clk_src = mode_r[MODE_CLK_LSB +: 2];
   assign ser_en = txcfg_r[TXCFG_EN];

   // reserved codes leave the unit idle
   assign proto_ok = (proto != PROTO_OFF) && (proto <= PROTO_SPI);
   assign USB_LOW_OUT = (proto == PROTO_USB) && (sub == SUB_USB_LOW);
   assign USB_HIGH_OUT = (proto == PROTO_USB) && (sub == SUB_USB_HIGH);

   always_comb begin
      case (clk_src)
         CLKSRC_OSC: tick = OSC_TICK_IN;
         CLKSRC_PLL: tick = PLL_TICK_IN;
         default: tick = 1'b0;
      endcase
   end

   // Shift clock toggles on each source tick while the protocol code is valid; a stopped source freezes it
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         sclk_r <= 1'b0;
      end else if (proto_ok && tick) begin
         sclk_r <= ~sclk_r;
      end
   end
   assign SHIFT_CLK_OUT = sclk_r;
   assign rise_ev = proto_ok & tick & ~sclk_r;
   assign fall_ev = proto_ok & tick & sclk_r;

   assign samp_rise = (proto == PROTO_SPI) ? sub[0] : 1'b1;
   assign drive_rise = (proto == PROTO_SPI) ? ~sub[1] : 1'b0;
   assign sample_ev = samp_rise ? rise_ev : fall_ev;
   assign drive_ev = drive_rise ? rise_ev : fall_ev;

   assign rx_bit = RX_DATA_IN ^ rxcfg_r[RXCFG_INV];
   // A zero count means a full 32-bit word
   assign rx_tgt = (rxcfg_r[4:0] == 5'h00) ? FULL_WORD : {1'b0, rxcfg_r[4:0]};
   // word completes at the programmed count
   assign rx_done = sample_ev && (({1'b0, rx_cnt_r} + 6'h01) == rx_tgt);

   // Deserializer
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         rx_shift_r <= '0;
         rx_cnt_r <= 5'h00;
         RX_WORD_OUT <= '0;
         RX_VALID_OUT <= 1'b0;
      end else begin
         RX_VALID_OUT <= rx_done;
         if (!proto_ok) begin
            rx_cnt_r <= 5'h00;
         end else if (sample_ev) begin
            rx_shift_r <= {rx_shift_r[30:0], rx_bit};
            rx_cnt_r <= rx_done ? 5'h00 : rx_cnt_r + 5'h01;
            if (rx_done) begin
               RX_WORD_OUT <= {rx_shift_r[30:0], rx_bit};
            end
         end
      end
   end

   // sync detection gated by the disable bit
   sync_detect u_sync (
      .clk_in(CLK_IN),
      .rst_b_in(RST_B_IN),
      .en_in(proto_ok && !rxcfg_r[RXCFG_SYNCDIS]),
      .bit_valid_in(sample_ev),
      .bit_in(rx_bit),
      .hit_out(sync_hit)
   );

   // Carrier edge tracking
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         carrier_r <= 1'b0;
      end else begin
         carrier_r <= CARRIER_IN;
      end
   end
   always_comb begin
      case (crs_ctrl_r)
         CRS_ON_DETECT: crs_ev = CARRIER_IN & ~carrier_r;
         CRS_ON_LOSS: crs_ev = ~CARRIER_IN & carrier_r;
         default: crs_ev = 1'b0;
      endcase
   end

   // Transmit holding buffer; it refills while the shifter is busy
   assign TX_READY_OUT = ~tx_hold_v_r;
   assign tx_tgt = (txcfg_r[4:0] == 5'h00) ? FULL_WORD : {1'b0, txcfg_r[4:0]};
   // loads only while the serializer is enabled
   assign tx_load = ser_en && drive_ev && tx_hold_v_r && (tx_left_r <= 6'h01);

   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         tx_hold_r <= '0;
         tx_hold_v_r <= 1'b0;
      end else if (tx_load) begin
         tx_hold_v_r <= 1'b0;
      end else if (TX_VALID_IN && !tx_hold_v_r) begin
         tx_hold_r <= TX_WORD_IN;
         tx_hold_v_r <= 1'b1;
      end
   end

   // Serializer
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         tx_state_r <= TX_IDLE;
         tx_shift_r <= '0;
         tx_left_r <= 6'h00;
         TX_DATA_OUT <= 1'b0;
      end else if (!ser_en) begin
         tx_state_r <= TX_IDLE;
         tx_left_r <= 6'h00;
         TX_DATA_OUT <= txcfg_r[TXCFG_INV];
      end else if (drive_ev) begin
         case (tx_state_r)
            TX_IDLE: begin
               if (tx_load) begin
                  tx_state_r <= TX_SHIFT;
                  tx_shift_r <= tx_hold_r;
                  tx_left_r <= tx_tgt;
                  TX_DATA_OUT <= tx_hold_r[0] ^ txcfg_r[TXCFG_INV];
               end
            end
            TX_SHIFT: begin
               // word ends after the programmed count
               if (tx_load) begin
                  tx_shift_r <= tx_hold_r;
                  tx_left_r <= tx_tgt;
                  TX_DATA_OUT <= tx_hold_r[0] ^ txcfg_r[TXCFG_INV];
               end else if (tx_left_r <= 6'h01) begin
                  tx_state_r <= TX_IDLE;
                  tx_left_r <= 6'h00;
                  TX_DATA_OUT <= txcfg_r[TXCFG_INV];
               end else begin
                  tx_shift_r <= {1'b0, tx_shift_r[31:1]};
                  tx_left_r <= tx_left_r - 6'h01;
                  TX_DATA_OUT <= tx_shift_r[1] ^ txcfg_r[TXCFG_INV];
               end
            end
            default: tx_state_r <= TX_IDLE;
         endcase
      end
   end
   assign TX_ACTIVE_OUT = (tx_state_r == TX_SHIFT);

   // Sticky status, cleared by reading it
   assign stat_rd = RD_IN && (ADDR_IN == OFS_STAT);
   sticky_bit u_syncf (
      .clk_in(CLK_IN),
      .rst_b_in(RST_B_IN),
      .set_in(sync_hit),
      .clr_in(stat_rd),
      .q_out(stat[STAT_SYNC])
   );
   sticky_bit u_txef (
      .clk_in(CLK_IN),
      .rst_b_in(RST_B_IN),
      .set_in(tx_load),
      .clr_in(stat_rd),
      .q_out(stat[STAT_TXE])
   );
   sticky_bit u_crsf (
      .clk_in(CLK_IN),
      .rst_b_in(RST_B_IN),
      .set_in(crs_ev),
      .clr_in(stat_rd),
      .q_out(stat[STAT_CRS])
   );
   assign IRQ_OUT = |(stat & mask_r);

   // Read data; unmapped offsets read zero
   always_comb begin
      case (ADDR_IN)
         OFS_MODE: rdata_nxt = mode_r;
         OFS_RXCFG: rdata_nxt = {1'b0, rxcfg_r};
         OFS_RXCNT: rdata_nxt = {1'b0, crs_ctrl_r, rx_cnt_r};
         OFS_TXCFG: rdata_nxt = txcfg_r;
         OFS_STAT: rdata_nxt = {4'h0, carrier_r, stat};
         OFS_MASK: rdata_nxt = {5'h00, mask_r};
         default: rdata_nxt = 8'h00;
      endcase
   end
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         RDATA_OUT <= 8'h00;
      end else if (RD_IN) begin
         RDATA_OUT <= rdata_nxt;
      end else begin
         RDATA_OUT <= 8'h00;
      end
   end

   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RST_B_IN);

   sequence s_sync_seen;
      sample_ev && !rxcfg_r[RXCFG_SYNCDIS] ##1 sync_hit;
   endsequence

   chk_proto_idle: assert property (!proto_ok |-> !sample_ev && !drive_ev)
      else $error("shift events with protocol off");
   chk_clk_stop: assert property (clk_src == CLKSRC_OFF |=> $stable(sclk_r))
      else $error("shift clock moved with source off");
   chk_usb_speed: assert property (USB_HIGH_OUT |-> !USB_LOW_OUT && sub == SUB_USB_HIGH)
      else $error("usb speed select wrong");
   chk_spi_edges: assert property (proto == PROTO_SPI && sub == 2'h0
      && sample_ev |-> fall_ev)
      else $error("spi mode 00 sampled on rising edge");
   chk_sync_off: assert property (rxcfg_r[RXCFG_SYNCDIS] [*2] |-> !sync_hit)
      else $error("sync hit while disabled");
   chk_rx_invert: assert property (sample_ev |=>
      rx_shift_r[0] == ($past(RX_DATA_IN) ^ $past(rxcfg_r[RXCFG_INV])))
      else $error("received bit polarity wrong");
   chk_rx_word: assert property (rx_done |=> RX_VALID_OUT && RX_WORD_OUT == rx_shift_r)
      else $error("received word not delivered");
   chk_crs_quiet: assert property (!crs_ctrl_r[1] |-> !crs_ev)
      else $error("carrier event with interrupt off");
   chk_crs_rise: assert property (crs_ctrl_r == CRS_ON_DETECT && $rose(CARRIER_IN)
      |=> stat[STAT_CRS])
      else $error("carrier detect not flagged");
   chk_count_ro: assert property (WR_IN && ADDR_IN == OFS_RXCNT && !sample_ev && proto_ok
      |=> $stable(rx_cnt_r))
      else $error("actual count changed by write");
   chk_ser_off: assert property (!ser_en |=> !TX_ACTIVE_OUT)
      else $error("serializer active while disabled");
   chk_tx_invert: assert property (tx_load && ser_en |=>
      TX_DATA_OUT == ($past(tx_hold_r[0]) ^ $past(txcfg_r[TXCFG_INV])))
      else $error("transmit bit polarity wrong");
   chk_tx_count: assert property (tx_load |=> tx_left_r == $past(tx_tgt))
      else $error("transmit word length wrong");
   chk_sync_sticky: assert property (s_sync_seen |=> stat[STAT_SYNC])
      else $error("sync flag not set");
   chk_txe_sticky: assert property (stat[STAT_TXE] && !stat_rd |=> stat[STAT_TXE])
      else $error("transmit empty flag lost");
endmodule // serdes_config_control

// File: serdes_cfg_pkg.sv
package serdes_cfg_pkg;
   // Register offsets on the plain register port
   localparam logic [2:0] OFS_MODE = 3'h0;
   localparam logic [2:0] OFS_RXCFG = 3'h1;
   localparam logic [2:0] OFS_RXCNT = 3'h2;
   localparam logic [2:0] OFS_TXCFG = 3'h3;
   localparam logic [2:0] OFS_STAT = 3'h4;
   localparam logic [2:0] OFS_MASK = 3'h5;
   // Values after reset
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [6:0] RST_RXCFG = 7'h00;
   localparam logic [1:0] RST_CRS = 2'h0;
   localparam logic [7:0] RST_TXCFG = 8'h00;
   localparam logic [2:0] RST_MASK = 3'h0;
   // Field positions
   localparam int MODE_PROTO_LSB = 4;
   localparam int MODE_SUB_LSB = 2;
   localparam int MODE_CLK_LSB = 0;
   localparam int RXCFG_SYNCDIS = 6;
   localparam int RXCFG_INV = 5;
   localparam int RXCNT_CRS_LSB = 5;
   localparam int TXCFG_EN = 7;
   localparam int TXCFG_INV = 5;
   localparam int STAT_SYNC = 0;
   localparam int STAT_TXE = 1;
   localparam int STAT_CRS = 2;
   localparam int STAT_CRSNOW = 3;
   // Protocol codes
   localparam logic [3:0] PROTO_OFF = 4'h0;
   localparam logic [3:0] PROTO_ENET = 4'h1;
   localparam logic [3:0] PROTO_USB = 4'h2;
   localparam logic [3:0] PROTO_UART = 4'h3;
   localparam logic [3:0] PROTO_I2C = 4'h4;
   localparam logic [3:0] PROTO_SPI = 4'h5;
   // Submode and clock source codes
   localparam logic [1:0] SUB_USB_LOW = 2'h1;
   localparam logic [1:0] SUB_USB_HIGH = 2'h2;
   localparam logic [1:0] CLKSRC_OFF = 2'h0;
   localparam logic [1:0] CLKSRC_OSC = 2'h2;
   localparam logic [1:0] CLKSRC_PLL = 2'h3;
   // Carrier control codes
   localparam logic [1:0] CRS_ON_DETECT = 2'h2;
   localparam logic [1:0] CRS_ON_LOSS = 2'h3;
   // Sync pattern, plain default
   localparam int SYNC_W = 8;
   localparam logic [7:0] SYNC_PATTERN = 8'h80;
   localparam logic [5:0] FULL_WORD = 6'h20;
   typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} tx_state_type;
endpackage

// File: sticky_bit.sv
`timescale 1ns/1ps
module sticky_bit (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic set_in,
   input wire logic clr_in,
   output logic q_out
);
   // Set wins over a clear in the same cycle
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         q_out <= 1'b0;
      end else begin
         q_out <= set_in | (q_out & ~clr_in);
      end
   end
endmodule // sticky_bit

// File: sync_detect.sv
`timescale 1ns/1ps
module sync_detect
   import serdes_cfg_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic en_in,
   input wire logic bit_valid_in,
   input wire logic bit_in,
   output logic hit_out
);
   logic [SYNC_W-1:0] hist_r;
   logic [SYNC_W-1:0] hist_nxt;
   assign hist_nxt = {hist_r[SYNC_W-2:0], bit_in};
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         hist_r <= '0;
         hit_out <= 1'b0;
      end else begin
         hit_out <= 1'b0;
         if (!en_in) begin
            // Flush so a stale history cannot match after re-enable
            hist_r <= '0;
         end else if (bit_valid_in) begin
            hist_r <= hist_nxt;
            hit_out <= (hist_nxt == SYNC_PATTERN);
         end
      end
   end
endmodule // sync_detect

// File: line_model.sv
`timescale 1ns/1ps
module line_model (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Block side of the line
   input wire logic sclk_in,
   input wire logic txd_in,
   input wire logic txa_in,
   output logic osc_out,
   output logic pll_out,
   output logic rxd_out,
   // Bench controls
   input wire logic load_in,
   input wire logic [31:0] word_in,
   input wire logic [5:0] len_in,
   input wire logic sfall_in,
   input wire logic dfall_in,
   output logic [31:0] cap_out,
   output logic [5:0] nbits_out
);
   logic [1:0] oc_r;
   logic [1:0] pc_r;
   logic sq_r;
   logic seen_r;
   logic [31:0] sh_r;
   logic [5:0] left_r;
   logic rise;
   logic fall;
   assign rise = sclk_in & ~sq_r;
   assign fall = ~sclk_in & sq_r;
   assign osc_out = (oc_r == 2'h3);
   assign pll_out = (pc_r == 2'h2);
   // Data moves on the edge the block does not sample, never before its first sample
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         oc_r <= 2'h0;
         pc_r <= 2'h0;
         sq_r <= 1'b0;
         seen_r <= 1'b0;
         sh_r <= 32'h0;
         left_r <= 6'h1;
         rxd_out <= 1'b0;
         cap_out <= 32'h0;
         nbits_out <= 6'h0;
      end else begin
         oc_r <= oc_r + 2'h1;
         pc_r <= (pc_r == 2'h2) ? 2'h0 : pc_r + 2'h1;
         sq_r <= sclk_in;
         if (load_in) begin
            sh_r <= word_in << (6'd32 - len_in);
            rxd_out <= word_in[len_in - 6'd1];
            left_r <= len_in;
            seen_r <= 1'b0;
            cap_out <= 32'h0;
            nbits_out <= 6'h0;
         end else begin
            seen_r <= seen_r | (sfall_in ? fall : rise);
            if (seen_r && (sfall_in ? rise : fall)) begin
               sh_r <= sh_r << 1;
               left_r <= (left_r > 6'h1) ? left_r - 6'h1 : left_r;
               // A released line toggles so a stale bit is never mistaken for data
               rxd_out <= (left_r > 6'h1) ? sh_r[30] : ~rxd_out;
            end
            if (txa_in && (dfall_in ? rise : fall)) begin
               cap_out <= {txd_in, cap_out[31:1]};
               nbits_out <= nbits_out + 6'h1;
            end
         end
      end
   end
endmodule // line_model

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top
   import serdes_cfg_pkg::*;
;
   logic CLK_IN, RST_B_IN, WR_IN, RD_IN, OSC_TICK_IN, PLL_TICK_IN, RX_DATA_IN, CARRIER_IN;
   logic TX_VALID_IN, IRQ_OUT, SHIFT_CLK_OUT, TX_DATA_OUT, TX_ACTIVE_OUT, USB_LOW_OUT;
   logic USB_HIGH_OUT, RX_VALID_OUT, TX_READY_OUT, p_load, p_sfall, p_dfall;
   logic [2:0] ADDR_IN;
   logic [7:0] WDATA_IN, RDATA_OUT, rd_val;
   logic [31:0] RX_WORD_OUT, TX_WORD_IN, p_word, cap;
   logic [5:0] p_len, nbits;
   int fail_count = 0;
   int checked = 0;
   always #12.5 CLK_IN = ~CLK_IN;
   serdes_config_control dut (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .ADDR_IN(ADDR_IN),
      .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
      .IRQ_OUT(IRQ_OUT), .OSC_TICK_IN(OSC_TICK_IN), .PLL_TICK_IN(PLL_TICK_IN),
      .RX_DATA_IN(RX_DATA_IN), .CARRIER_IN(CARRIER_IN), .SHIFT_CLK_OUT(SHIFT_CLK_OUT),
      .TX_DATA_OUT(TX_DATA_OUT), .TX_ACTIVE_OUT(TX_ACTIVE_OUT), .USB_LOW_OUT(USB_LOW_OUT),
      .USB_HIGH_OUT(USB_HIGH_OUT), .RX_WORD_OUT(RX_WORD_OUT), .RX_VALID_OUT(RX_VALID_OUT),
      .TX_WORD_IN(TX_WORD_IN), .TX_VALID_IN(TX_VALID_IN), .TX_READY_OUT(TX_READY_OUT));
   line_model line (.clk_in(CLK_IN), .rst_b_in(RST_B_IN), .sclk_in(SHIFT_CLK_OUT),
      .txd_in(TX_DATA_OUT), .txa_in(TX_ACTIVE_OUT), .osc_out(OSC_TICK_IN),
      .pll_out(PLL_TICK_IN), .rxd_out(RX_DATA_IN), .load_in(p_load), .word_in(p_word),
      .len_in(p_len), .sfall_in(p_sfall), .dfall_in(p_dfall), .cap_out(cap),
      .nbits_out(nbits));
   task automatic report_and_stop();
      if (fail_count == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge CLK_IN);
      #1;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge CLK_IN);
      ADDR_IN <= a;
      WDATA_IN <= d;
      WR_IN <= 1'b1;
      @(posedge CLK_IN);
      WR_IN <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a);
      @(posedge CLK_IN);
      ADDR_IN <= a;
      RD_IN <= 1'b1;
      @(posedge CLK_IN);
      RD_IN <= 1'b0;
      #1 rd_val = RDATA_OUT;
   endtask
   task automatic reg_case();
      logic [7:0] ex [8];
      ex = '{8'hFF, 8'h7F, 8'h60, 8'hBF, 8'h00, 8'h07, 8'h00, 8'h00};
      for (int a = 0; a < 8; a++) begin
         rd(a[2:0]);
         cmp("reset_value", 8'h00, rd_val);
      end
      for (int a = 0; a < 8; a++) begin
         if (a != 4) begin
            wr(a[2:0], 8'hFF);
            rd(a[2:0]);
            cmp("readback", ex[a], rd_val);
            wr(a[2:0], 8'h00);
         end
      end
   endtask
   task automatic usb_case();
      for (int s = 0; s < 4; s++) begin
         wr(OFS_MODE, {PROTO_USB, s[1:0], CLKSRC_OFF});
         cyc(1);
         cmp("usb_low", s == 1, USB_LOW_OUT);
         cmp("usb_high", s == 2, USB_HIGH_OUT);
      end
   endtask
   task automatic clk_case(input logic [7:0] m, input int e);
      int t;
      logic p;
      wr(OFS_MODE, m);
      cyc(4);
      p = SHIFT_CLK_OUT;
      t = 0;
      repeat (24) begin
         cyc(1);
         if (SHIFT_CLK_OUT !== p)
            t++;
         p = SHIFT_CLK_OUT;
      end
      cmp("shift_clk_toggles", e, t);
   endtask
   task automatic link_case(input logic [3:0] pr, input logic [1:0] sb, input logic [4:0] c,
      input logic sd, ri, ti, input logic [31:0] rw, tw, input logic [7:0] es);
      int n;
      int k;
      logic [31:0] mk;
      n = (c == 0) ? 32 : c;
      mk = (n == 32) ? 32'hFFFFFFFF : (32'h1 << n) - 32'h1;
      wr(OFS_MODE, 8'h00);
      wr(OFS_RXCFG, {1'b0, sd, ri, c});
      wr(OFS_TXCFG, {1'b1, 1'b0, ti, c});
      rd(OFS_STAT);
      @(posedge CLK_IN);
      p_sfall <= (pr == PROTO_SPI) & ~sb[0];
      p_dfall <= (pr == PROTO_SPI) ? sb[1] : 1'b1;
      p_word <= rw;
      p_len <= 6'(n);
      p_load <= 1'b1;
      TX_WORD_IN <= tw;
      TX_VALID_IN <= 1'b1;
      #1 cmp("tx_ready", 1, TX_READY_OUT);
      @(posedge CLK_IN);
      p_load <= 1'b0;
      TX_VALID_IN <= 1'b0;
      wr(OFS_MODE, {pr, sb, CLKSRC_OSC});
      for (k = 0; k < 600 && RX_VALID_OUT !== 1'b1; k++)
         cyc(1);
      cmp("rx_valid", 1, RX_VALID_OUT);
      cmp("rx_word", (rw ^ {32{ri}}) & mk, RX_WORD_OUT & mk);
      for (k = 0; k < 600 && TX_ACTIVE_OUT !== 1'b0; k++)
         cyc(1);
      cyc(2);
      cmp("tx_bits", n, nbits);
      cmp("tx_word", (tw ^ {32{ti}}) & mk, cap >> (32 - n));
      cmp("tx_idle", ti, TX_DATA_OUT);
      rd(OFS_STAT);
      cmp("status", es, rd_val);
      rd(OFS_STAT);
      cmp("status_cleared", 8'h00, rd_val);
   endtask
   task automatic crs_case(input logic [1:0] ct, input logic [2:0] mk, input logic lv,
      input logic ei, input logic [7:0] es);
      wr(OFS_RXCNT, {1'b0, ct, 5'h00});
      wr(OFS_MASK, {5'h00, mk});
      @(posedge CLK_IN);
      CARRIER_IN <= ~lv;
      cyc(4);
      rd(OFS_STAT);
      @(posedge CLK_IN);
      CARRIER_IN <= lv;
      cyc(4);
      cmp("irq", ei, IRQ_OUT);
      rd(OFS_STAT);
      cmp("carrier_status", es, rd_val);
      cmp("irq_after_read", 0, IRQ_OUT);
   endtask
   task automatic tx_off_case();
      int k;
      wr(OFS_MODE, 8'h00);
      wr(OFS_TXCFG, 8'h08);
      wr(OFS_MODE, {PROTO_UART, 2'h0, CLKSRC_OSC});
      @(posedge CLK_IN);
      TX_WORD_IN <= 32'h5A;
      TX_VALID_IN <= 1'b1;
      @(posedge CLK_IN);
      TX_VALID_IN <= 1'b0;
      k = 0;
      repeat (100) begin
         cyc(1);
         if (TX_ACTIVE_OUT !== 1'b0)
            k++;
      end
      cmp("tx_active_off", 0, k);
      wr(OFS_TXCFG, 8'h88);
      for (k = 0; k < 100 && TX_ACTIVE_OUT !== 1'b1; k++)
         cyc(1);
      cmp("tx_active_on", 1, TX_ACTIVE_OUT);
   endtask
   initial begin
      repeat (40000) @(posedge CLK_IN);
      fail_count++;
      report_and_stop();
   end
   initial begin
      CLK_IN = 1'b0;
      RST_B_IN = 1'b0;
      {WR_IN, RD_IN, ADDR_IN, WDATA_IN, CARRIER_IN, TX_WORD_IN, TX_VALID_IN} = '0;
      {p_load, p_word, p_sfall} = '0;
      p_len = 6'h1;
      p_dfall = 1'b1;
      repeat (16) @(posedge CLK_IN);
      RST_B_IN <= 1'b1;
      reg_case();
      usb_case();
      for (int p = 0; p < 16; p++)
         clk_case({p[3:0], 2'h0, CLKSRC_OSC}, (p >= 1 && p <= 5) ? 6 : 0);
      clk_case({PROTO_UART, 2'h0, CLKSRC_OFF}, 0);
      clk_case({PROTO_UART, 2'h0, 2'h1}, 0);
      clk_case({PROTO_UART, 2'h0, CLKSRC_PLL}, 8);
      link_case(PROTO_UART, 2'h0, 5'd8, 1, 0, 0, 32'hB5, 32'h3C, 8'h02);
      link_case(PROTO_ENET, 2'h0, 5'd8, 1, 1, 1, 32'hB5, 32'h3C, 8'h02);
      link_case(PROTO_I2C, 2'h0, 5'd0, 1, 0, 1, 32'hC0FFEE15, 32'h1234ABCD, 8'h02);
      link_case(PROTO_USB, SUB_USB_HIGH, 5'd31, 1, 1, 0, 32'h6ABCDEF1, 32'h7FFF0001, 8'h02);
      for (int s = 0; s < 4; s++)
         link_case(PROTO_SPI, s[1:0], 5'd12, 1, 0, 0, 32'hA5C, 32'h6F3, 8'h02);
      link_case(PROTO_UART, 2'h0, 5'd8, 0, 0, 0, 32'h80, 32'h01, 8'h03);
      link_case(PROTO_UART, 2'h0, 5'd8, 1, 0, 0, 32'h80, 32'h01, 8'h02);
      link_case(PROTO_UART, 2'h0, 5'd8, 0, 1, 0, 32'h7F, 32'h01, 8'h03);
      crs_case(CRS_ON_DETECT, 3'h4, 1, 1, 8'h0C);
      crs_case(CRS_ON_DETECT, 3'h0, 1, 0, 8'h0C);
      crs_case(CRS_ON_LOSS, 3'h4, 0, 1, 8'h04);
      crs_case(CRS_ON_LOSS, 3'h4, 1, 0, 8'h08);
      crs_case(2'h0, 3'h4, 0, 0, 8'h00);
      crs_case(2'h1, 3'h4, 1, 0, 8'h08);
      crs_case(2'h0, 3'h4, 0, 0, 8'h00);
      tx_off_case();
      report_and_stop();
   end
endmodule // tb_top
